// file: design/fci_core.sv
// Purpose: Fax service-class command interpreter with S-register store
// Assumes: Commands arrive pre-parsed as command words on the register port
// Notes:   One result per command, plus one when a run ends; software drains results on interrupt
//
// The address map and the plain strobed port were chosen for this implementation.
`default_nettype none

module fci_core
    import fci_pkg::*;
#(
    parameter int unsigned NSREG = 16
) (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [2:0]               addr,
    input  wire logic [15:0]              wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [15:0]              rdata,
    output logic                          irq,
    input  wire logic                     host_char_stb,
    input  wire logic                     op_done_stb,
    input  wire logic                     tx_byte_ack,
    output logic                          off_hook,
    output var fci_mod_t                  tx_mod,
    output var fci_mod_t                  rx_mod,
    output logic                          hdlc_mode,
    output logic                          test_active,
    output logic      [7:0]               test_byte,
    output logic                          busy,
    input  wire logic                     nv_present,
    input  wire logic                     nv_parity_ok,
    output logic      [$clog2(NSREG)-1:0] nv_addr,
    input  wire logic [7:0]               nv_data
);

    localparam int IW = $clog2(NSREG);

    fci_state_t       state;
    fci_state_t       next_state;
    fci_cmd_t         run_op;
    logic             svc_class;
    logic             load_user;
    logic [7:0]       sreg [NSREG];
    logic [7:0]       res_code;
    logic [11:0]      res_value;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [INT_W-1:0] int_ev;
    logic [2:0]       pat_sel;

    // Port decode; commands only land while idle, so nothing interrupts a load
    fci_cmd_word_t cmd;
    logic          idle;
    logic          cmd_wr;
    logic          sreg_wr;
    logic          mask_wr;
    logic          stat_rd;
    assign cmd     = fci_cmd_word_t'(wdata);
    assign idle    = (state == ST_IDLE);
    assign cmd_wr  = wr && (addr == ADDR_CMD) && idle;
    assign sreg_wr = wr && (addr == ADDR_SREG) && idle;
    assign mask_wr = wr && (addr == ADDR_INT_MASK);
    assign stat_rd = rd && (addr == ADDR_INT_STAT);

    // Parameter defaults per command
    logic [7:0] dflt_param;
    logic [7:0] param_eff;
    logic [2:0] pat_eff;
    assign dflt_param = (cmd.op == CMD_FAX_TRANSMIT_DATA) ? RATE_48 :
                        (cmd.op == CMD_FAX_RECEIVE_DATA)  ? RATE_48 :
                        (cmd.op == CMD_RECEIVE_TEST)      ? RATE_48 :
                        (cmd.op == CMD_FRAMED_TRANSMIT)   ? RATE_V21 :
                        (cmd.op == CMD_TRANSMIT_TEST)     ? RATE_96 :
                        DFLT_FRH;
    assign param_eff  = cmd.use_dflt ? dflt_param : cmd.param;
    assign pat_eff    = cmd.use_dflt ? DFLT_PATTERN : cmd.pattern;

    // Modulation lookup; unframed receive paths only carry V.27 ter, framed receive carries V.21
    fci_mod_t hs_mod;
    fci_mod_t lo_mod;
    fci_mod_t v21_mod;
    fci_mod_t pick_mod;
    logic     is_tx;
    logic     is_rx;
    logic     is_framed;
    assign hs_mod   = (param_eff == RATE_24) ? MOD_V27_2400 :
                      (param_eff == RATE_48) ? MOD_V27_4800 :
                      (param_eff == RATE_72) ? MOD_V29_7200 :
                      (param_eff == RATE_96) ? MOD_V29_9600 : MOD_NONE;
    assign lo_mod   = (hs_mod == MOD_V27_2400 || hs_mod == MOD_V27_4800) ? hs_mod : MOD_NONE;
    assign v21_mod  = (param_eff == RATE_V21) ? MOD_V21_300 : MOD_NONE;
    assign is_tx     = (cmd.op == CMD_FAX_TRANSMIT_DATA) || (cmd.op == CMD_TRANSMIT_TEST);
    assign is_rx     = (cmd.op == CMD_FAX_RECEIVE_DATA) || (cmd.op == CMD_RECEIVE_TEST);
    assign is_framed = (cmd.op == CMD_FRAMED_TRANSMIT) || (cmd.op == CMD_FRAMED_RECEIVE);
    assign pick_mod  = is_tx ? hs_mod : is_rx ? lo_mod : is_framed ? v21_mod : MOD_NONE;

    // Validity of fax commands
    logic is_fax;
    logic needs_line;
    logic pat_ok;
    logic fax_bad;
    logic start_run;
    logic run_end;
    assign is_fax     = is_tx || is_rx || is_framed;
    assign needs_line = is_framed || (cmd.op == CMD_FAX_TRANSMIT_DATA) || (cmd.op == CMD_FAX_RECEIVE_DATA);
    assign pat_ok     = (cmd.op != CMD_TRANSMIT_TEST) || (pat_eff == PAT_ASCII) || (pat_eff == PAT_ZEROS) ||
                        (pat_eff == PAT_SLIDE0) || (pat_eff == PAT_SLIDE1);
    assign fax_bad    = (svc_class != CLASS_FAX1) ||
                        (needs_line && !off_hook) ||
                        (pick_mod == MOD_NONE) || !pat_ok;
    assign start_run  = cmd_wr && is_fax && !fax_bad;
    // Test pattern ignores datapath completion: only the host can end it
    assign run_end    = (state == ST_RUN) &&
                        (host_char_stb || (op_done_stb && run_op != CMD_TRANSMIT_TEST));

    // Query decode and three-digit conversion
    logic        q_ok;
    logic [7:0]  q_val;
    logic [11:0] q_bcd;
    logic [7:0]  cmd_res;
    assign q_ok  = (cmd.param < NSREG);
    assign q_val = sreg[cmd.param[IW-1:0]];
    assign q_bcd = {4'(q_val / 8'h64), 4'((q_val / 8'h0A) % 8'h0A), 4'(q_val % 8'h0A)};
    assign cmd_res = (cmd.op == CMD_SERVICE_CLASS_SELECT) ? ((cmd.param <= 8'h01) ? RES_OK : RES_ERROR) :
                     is_fax ? (fax_bad ? RES_ERROR : RES_CONNECT) :
                     (cmd.op == CMD_SREG_QUERY) ? (q_ok ? RES_VALUE : RES_ERROR) :
                     (cmd.op >= CMD_LINE_END && cmd.op <= CMD_HOOK_OFF) ? RES_OK : RES_ERROR;

    // Default-store sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_PICK: next_state = ST_LOAD;
            ST_LOAD: next_state = (nv_addr == IW'(NSREG - 1)) ? ST_IDLE : ST_LOAD;
            ST_IDLE: begin
                if (start_run) begin
                    next_state = ST_RUN;
                end else if (cmd_wr && cmd.op == CMD_FACTORY_DEFAULTS) begin
                    next_state = ST_LOAD;
                end else if (cmd_wr && cmd.op == CMD_MODEM_RESET) begin
                    next_state = ST_PICK;
                end
            end
            ST_RUN:  next_state = run_end ? ST_IDLE : ST_RUN;
            default: next_state = ST_PICK;
        endcase
    end

    always_ff @(posedge clk) begin
        state <= !rst_n ? ST_PICK : next_state;
        busy  <= !rst_n ? 1'b1 : (next_state != ST_IDLE);
    end

    // Store health is sampled after reset release, never at reset itself
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            load_user <= 1'b0;
            nv_addr   <= '0;
        end else if (state == ST_PICK) begin
            load_user <= nv_present && nv_parity_ok;
            nv_addr   <= '0;
        end else if (cmd_wr && cmd.op == CMD_FACTORY_DEFAULTS) begin
            load_user <= 1'b0;
            nv_addr   <= '0;
        end else if (state == ST_LOAD) begin
            nv_addr   <= nv_addr + IW'(1);
        end
    end

    // S-register file; the store answers in the cycle its address stands
    logic [7:0] fac_val;
    logic [7:0] load_val;
    assign fac_val  = (nv_addr < NSREG_DOC) ? SREG_FACTORY[nv_addr] : 8'h00;
    assign load_val = load_user ? nv_data : fac_val;
    for (genvar i = 0; i < NSREG; i++) begin : g_sreg
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                sreg[i] <= 8'h00;
            end else if (state == ST_LOAD && nv_addr == IW'(i)) begin
                sreg[i] <= load_val;
            end else if (sreg_wr && wdata[8 +: IW] == IW'(i)) begin
                sreg[i] <= wdata[7:0];
            end
        end
    end

    // Class, hook and result
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            svc_class <= CLASS_DATA;
            off_hook  <= 1'b0;
            res_code  <= RES_OK;
            res_value <= 12'h000;
        end else begin
            if (cmd_wr && cmd.op == CMD_SERVICE_CLASS_SELECT && cmd.param <= 8'h01) begin
                svc_class <= cmd.param[0];
            end
            if (cmd_wr && cmd.op == CMD_HOOK_ON) begin
                off_hook <= 1'b0;
            end else if ((cmd_wr && cmd.op == CMD_HOOK_OFF) || (start_run && cmd.op == CMD_RECEIVE_TEST)) begin
                off_hook <= 1'b1;
            end
            if (cmd_wr) begin
                res_code  <= cmd_res;
                res_value <= (cmd.op == CMD_SREG_QUERY && q_ok) ? q_bcd : 12'h000;
            end else if (run_end) begin
                res_code  <= RES_OK;
                res_value <= 12'h000;
            end
        end
    end

    // Datapath mode outputs
    always_ff @(posedge clk) begin
        if (!rst_n || run_end) begin
            tx_mod    <= MOD_NONE;
            rx_mod    <= MOD_NONE;
            hdlc_mode <= 1'b0;
        end else if (start_run) begin
            tx_mod    <= (is_tx || cmd.op == CMD_FRAMED_TRANSMIT) ? pick_mod : MOD_NONE;
            rx_mod    <= (is_rx || cmd.op == CMD_FRAMED_RECEIVE) ? pick_mod : MOD_NONE;
            hdlc_mode <= is_framed;
        end
    end

    always_ff @(posedge clk) begin
        run_op <= !rst_n ? CMD_LINE_END : (start_run ? cmd.op : run_op);
    end

    // Test pattern source; a byte advances each time the modulator takes one
    logic [7:0] pat_seed;
    logic [7:0] pat_next;
    assign pat_seed = (pat_eff == PAT_SLIDE0) ? SLIDE0_SEED :
                      (pat_eff == PAT_SLIDE1) ? SLIDE1_SEED :
                      (pat_eff == PAT_ZEROS)  ? 8'h00 : ASCII_FIRST;
    assign pat_next = (pat_sel == PAT_ASCII) ? ((test_byte == ASCII_LAST) ? ASCII_FIRST : test_byte + 8'h01) :
                      (pat_sel == PAT_ZEROS) ? 8'h00 : {test_byte[6:0], test_byte[7]};
    always_ff @(posedge clk) begin
        if (!rst_n || run_end) begin
            test_active <= 1'b0;
            test_byte   <= 8'h00;
            pat_sel     <= PAT_ASCII;
        end else if (start_run && cmd.op == CMD_TRANSMIT_TEST) begin
            test_active <= 1'b1;
            test_byte   <= pat_seed;
            pat_sel     <= pat_eff;
        end else if (test_active && tx_byte_ack) begin
            test_byte   <= pat_next;
        end
    end

    // Sticky events; a new event in the clearing read cycle survives it
    assign int_ev[INT_RESULT] = cmd_wr || run_end;
    assign int_ev[INT_DONE]   = run_end;
    assign int_ev[INT_LOADED] = (state == ST_LOAD) && (next_state == ST_IDLE);
    for (genvar b = 0; b < INT_W; b++) begin : g_int
        always_ff @(posedge clk) begin
            int_stat[b] <= !rst_n ? 1'b0 : (int_ev[b] || (int_stat[b] && !stat_rd));
        end
    end

    always_ff @(posedge clk) begin
        int_mask <= !rst_n ? '0 : (mask_wr ? wdata[INT_W-1:0] : int_mask);
        irq      <= !rst_n ? 1'b0 : |(int_stat & int_mask);
    end

    // Read mux; unmapped offsets read zero
    fci_status_t status;
    logic [15:0] rd_mux;
    assign status = '{zero: 8'h00, busy: busy, off_hook: off_hook, fax_class: svc_class,
                      hdlc: hdlc_mode, op: run_op};
    assign rd_mux = (addr == ADDR_STATUS)   ? 16'(status) :
                    (addr == ADDR_RESULT)   ? {8'h00, res_code} :
                    (addr == ADDR_VALUE)    ? {4'h0, res_value} :
                    (addr == ADDR_INT_STAT) ? 16'(int_stat) :
                    (addr == ADDR_INT_MASK) ? 16'(int_mask) : 16'h0000;
    always_ff @(posedge clk) begin
        rdata <= (!rst_n || !rd) ? 16'h0000 : rd_mux;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CLASS_GATE: assert property (
        cmd_wr && is_fax && svc_class == CLASS_DATA |=> res_code == RES_ERROR && state == ST_IDLE)
        else $error("fax command accepted in data class");
    AST_ONHOOK_ERR: assert property (
        cmd_wr && needs_line && !off_hook |=> res_code == RES_ERROR && tx_mod == MOD_NONE && rx_mod == MOD_NONE)
        else $error("on-hook fax command not rejected");
    AST_TX_MOD: assert property (
        start_run && cmd.op == CMD_FAX_TRANSMIT_DATA && cmd.use_dflt |=> tx_mod == MOD_V27_4800 && busy)
        else $error("transmit default rate wrong");
    AST_RX_MOD: assert property (
        start_run && cmd.op == CMD_FAX_RECEIVE_DATA && param_eff == RATE_24 |=> rx_mod == MOD_V27_2400)
        else $error("receive rate wrong");
    AST_RX_NO_V29: assert property (
        cmd_wr && cmd.op == CMD_FAX_RECEIVE_DATA && (param_eff == RATE_72 || param_eff == RATE_96)
        |=> res_code == RES_ERROR && rx_mod == MOD_NONE)
        else $error("receive accepted a V.29 rate");
    AST_FRAMED_TX: assert property (
        start_run && cmd.op == CMD_FRAMED_TRANSMIT |=> tx_mod == MOD_V21_300 && hdlc_mode)
        else $error("framed transmit mode wrong");
    AST_FRAMED_RX_DFLT: assert property (
        cmd_wr && cmd.op == CMD_FRAMED_RECEIVE && cmd.use_dflt |=> res_code == RES_ERROR && !hdlc_mode)
        else $error("framed receive default parameter not zero");
    AST_RX_TEST_HOOK: assert property (
        start_run && cmd.op == CMD_RECEIVE_TEST |=> off_hook && rx_mod != MOD_NONE && tx_mod == MOD_NONE)
        else $error("receive test did not go off-hook");
    AST_TX_TEST_DFLT: assert property (
        start_run && cmd.op == CMD_TRANSMIT_TEST && cmd.use_dflt |=> tx_mod == MOD_V29_9600 && test_byte == ASCII_FIRST)
        else $error("transmit test defaults wrong");
    AST_TEST_STOP: assert property (
        test_active && host_char_stb |=> !test_active && tx_mod == MOD_NONE && !busy)
        else $error("test pattern did not stop on host character");
    AST_TEST_HOLD: assert property (
        test_active && !host_char_stb |=> test_active)
        else $error("test pattern ended without host character");
    AST_ASCII_WRAP: assert property (
        test_active && pat_sel == PAT_ASCII && tx_byte_ack && !host_char_stb && test_byte == ASCII_LAST
        |=> test_byte == ASCII_FIRST)
        else $error("ascii pattern did not wrap");
    AST_SLIDE1: assert property (
        test_active && pat_sel == PAT_SLIDE1 && test_byte == SLIDE1_SEED && tx_byte_ack && !host_char_stb
        |=> test_byte == 8'h02)
        else $error("sliding one pattern wrong");
    AST_FACTORY: assert property (
        cmd_wr && cmd.op == CMD_FACTORY_DEFAULTS |=> state == ST_LOAD && !load_user && nv_addr == '0)
        else $error("factory load not started");
    AST_USER_LOAD: assert property (
        state == ST_PICK && nv_present && nv_parity_ok |=> load_user && state == ST_LOAD)
        else $error("user defaults not chosen with good store");
    AST_QUERY: assert property (
        cmd_wr && cmd.op == CMD_SREG_QUERY && q_ok |=> res_code == RES_VALUE && res_value == $past(q_bcd))
        else $error("query result wrong");

    COV_TX_TEST_ABORT: cover property (test_active ##[1:20] host_char_stb);
    COV_QUERY_LINE:    cover property (cmd_wr && cmd.op == CMD_SREG_QUERY ##[1:5] cmd_wr && cmd.op == CMD_LINE_END);
    COV_USER_LOAD:     cover property (state == ST_PICK && nv_present && nv_parity_ok);
    COV_RX_DONE:       cover property (state == ST_RUN && run_op == CMD_FAX_RECEIVE_DATA && op_done_stb);

endmodule

`default_nettype wire

// file: design/fci_pkg.sv
// Purpose: Shared constants and types for the fax command interpreter
// Assumes: 16-bit register port, single 40 MHz clock domain
// Notes:   Rates are carried as their decimal command values (24, 48, ...)
`default_nettype none

package fci_pkg;

    // Register port offsets
    localparam logic [2:0] ADDR_CMD      = 3'h0;
    localparam logic [2:0] ADDR_STATUS   = 3'h1;
    localparam logic [2:0] ADDR_RESULT   = 3'h2;
    localparam logic [2:0] ADDR_VALUE    = 3'h3;
    localparam logic [2:0] ADDR_INT_STAT = 3'h4;
    localparam logic [2:0] ADDR_INT_MASK = 3'h5;
    localparam logic [2:0] ADDR_SREG     = 3'h6;

    // Command opcodes written to the command register
    typedef enum logic [3:0] {
        CMD_SERVICE_CLASS_SELECT = 4'h0,
        CMD_FAX_TRANSMIT_DATA    = 4'h1,
        CMD_FAX_RECEIVE_DATA     = 4'h2,
        CMD_FRAMED_TRANSMIT      = 4'h3,
        CMD_FRAMED_RECEIVE       = 4'h4,
        CMD_RECEIVE_TEST         = 4'h5,
        CMD_TRANSMIT_TEST        = 4'h6,
        CMD_SREG_QUERY           = 4'h7,
        CMD_LINE_END             = 4'h8,
        CMD_FACTORY_DEFAULTS     = 4'h9,
        CMD_MODEM_RESET          = 4'hA,
        CMD_HOOK_ON              = 4'hB,
        CMD_HOOK_OFF             = 4'hC
    } fci_cmd_t;

    // Command word layout: param[15:8], use_dflt[7], pattern[6:4], op[3:0]
    typedef struct packed {
        logic [7:0] param;
        logic       use_dflt;
        logic [2:0] pattern;
        fci_cmd_t   op;
    } fci_cmd_word_t;

    // Line modulation selected for the datapath
    typedef enum logic [2:0] {
        MOD_NONE      = 3'b000,
        MOD_V27_2400  = 3'b001,
        MOD_V27_4800  = 3'b010,
        MOD_V29_7200  = 3'b011,
        MOD_V29_9600  = 3'b100,
        MOD_V21_300   = 3'b101
    } fci_mod_t;

    typedef enum logic [1:0] {
        ST_PICK = 2'b00,
        ST_LOAD = 2'b01,
        ST_IDLE = 2'b10,
        ST_RUN  = 2'b11
    } fci_state_t;

    // Status register layout
    typedef struct packed {
        logic [7:0] zero;
        logic       busy;
        logic       off_hook;
        logic       fax_class;
        logic       hdlc;
        fci_cmd_t   op;
    } fci_status_t;

    // Result codes
    localparam logic [7:0] RES_OK      = 8'h00;
    localparam logic [7:0] RES_CONNECT = 8'h01;
    localparam logic [7:0] RES_ERROR   = 8'h04;
    localparam logic [7:0] RES_VALUE   = 8'h10;

    // Rate parameters and defaults
    localparam logic [7:0] RATE_24      = 8'h18;
    localparam logic [7:0] RATE_48      = 8'h30;
    localparam logic [7:0] RATE_72      = 8'h48;
    localparam logic [7:0] RATE_96      = 8'h60;
    localparam logic [7:0] RATE_V21     = 8'h03;
    localparam logic [7:0] DFLT_FRH     = 8'h00;
    localparam logic [2:0] DFLT_PATTERN = 3'h0;
    localparam logic       CLASS_DATA   = 1'b0;
    localparam logic       CLASS_FAX1   = 1'b1;

    // Test patterns
    localparam logic [2:0] PAT_ASCII   = 3'h0;
    localparam logic [2:0] PAT_ZEROS   = 3'h1;
    localparam logic [2:0] PAT_SLIDE0  = 3'h3;
    localparam logic [2:0] PAT_SLIDE1  = 3'h5;
    localparam logic [7:0] ASCII_FIRST = 8'h20;
    localparam logic [7:0] ASCII_LAST  = 8'h7F;
    localparam logic [7:0] SLIDE0_SEED = 8'hFE;
    localparam logic [7:0] SLIDE1_SEED = 8'h01;

    // Interrupt bits
    localparam int unsigned INT_W      = 3;
    localparam int unsigned INT_RESULT = 0;
    localparam int unsigned INT_DONE   = 1;
    localparam int unsigned INT_LOADED = 2;

    // Factory S-register values; entries beyond the table load zero
    localparam int unsigned NSREG_DOC = 12;
    localparam logic [7:0] SREG_FACTORY [NSREG_DOC] = '{
        8'h00, 8'h00, 8'h2B, 8'h0D, 8'h0A, 8'h08,
        8'h02, 8'h1E, 8'h02, 8'h06, 8'h0E, 8'h5F
    };

endpackage

`default_nettype wire

// file: verif/fax_class1_command_interpreter_tb_top.sv
// Purpose: Self-checking bench for the fax command interpreter
// Assumes: Store fitted with good parity until the last power-up
// Notes:   Load interrupt check first, then command rows, test patterns, queries and defaults
`default_nettype none
module fax_class1_command_interpreter_tb_top;
    import fci_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [15:0] c; logic [7:0] r; fci_mod_t t; fci_mod_t x;} fci_row_t;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, host_char_stb = 0, op_done_stb = 0, tx_byte_ack = 0;
    logic nv_present = 1, nv_parity_ok = 1, irq, off_hook, hdlc_mode, test_active, busy;
    logic [2:0] addr = 0;
    logic [15:0] wdata = 0, rdata, v;
    logic [7:0] test_byte, nv_data;
    logic [3:0] nv_addr;
    fci_mod_t tx_mod, rx_mod;
    int failures = 0, checks_done = 0;
    // Ordinary commands: word, result, transmit and receive modulation
    fci_row_t rows [13] = '{'{16'h3001, RES_ERROR, MOD_NONE, MOD_NONE}, '{16'h0100, RES_OK, MOD_NONE, MOD_NONE},
        '{16'h3001, RES_ERROR, MOD_NONE, MOD_NONE}, '{16'h000C, RES_OK, MOD_NONE, MOD_NONE},
        '{16'h1801, RES_CONNECT, MOD_V27_2400, MOD_NONE}, '{16'h6001, RES_CONNECT, MOD_V29_9600, MOD_NONE},
        '{16'h0081, RES_CONNECT, MOD_V27_4800, MOD_NONE}, '{16'h1802, RES_CONNECT, MOD_NONE, MOD_V27_2400},
        '{16'h4802, RES_ERROR, MOD_NONE, MOD_NONE}, '{16'h0083, RES_CONNECT, MOD_V21_300, MOD_NONE},
        '{16'h0304, RES_CONNECT, MOD_NONE, MOD_V21_300}, '{16'h0084, RES_ERROR, MOD_NONE, MOD_NONE},
        '{16'h0085, RES_CONNECT, MOD_NONE, MOD_V27_4800}};

    fci_core #(.NSREG(16)) dut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .irq, .host_char_stb,
        .op_done_stb, .tx_byte_ack, .off_hook, .tx_mod, .rx_mod, .hdlc_mode, .test_active, .test_byte,
        .busy, .nv_present, .nv_parity_ok, .nv_addr, .nv_data);
    fci_nv_model nv (.nv_addr(nv_addr), .nv_data(nv_data));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 0;
        #1 d = rdata;
    endtask
    // One-cycle host character (h=1), or modulator acknowledge with a datapath done (h=0)
    task automatic strobe(input logic h);
        @(posedge clk) {host_char_stb, tx_byte_ack, op_done_stb} <= {h, !h, !h};
        @(posedge clk) {host_char_stb, tx_byte_ack, op_done_stb} <= 3'b000;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 64; i++) begin
            @(posedge clk);
            if (busy === 1'b0) return;
        end
        failures++;
        complete_run();
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        wait_idle();
        wr_reg(ADDR_INT_MASK, 16'h0004);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b1);
        rd_reg(ADDR_INT_STAT, v);
        chk(v[2], 1'b1);
        rd_reg(3'h7, v);
        chk(v, 16'h0000);
        // Each row: issue, read result, check modulation, then abort from the host
        foreach (rows[i]) begin
            wr_reg(ADDR_CMD, rows[i].c);
            rd_reg(ADDR_RESULT, v);
            chk(v, rows[i].r);
            chk(tx_mod, rows[i].t);
            chk(rx_mod, rows[i].x);
            chk(hdlc_mode, rows[i].t == MOD_V21_300 || rows[i].x == MOD_V21_300);
            strobe(1'b1);
        end
        // On-hook framed transmit is refused; receive test takes the line itself
        wr_reg(ADDR_CMD, 16'h000B);
        wr_reg(ADDR_CMD, 16'h0083);
        rd_reg(ADDR_RESULT, v);
        chk(v, RES_ERROR);
        wr_reg(ADDR_CMD, 16'h0085);
        #1 chk(off_hook, 1'b1);
        strobe(1'b1);
        wr_reg(ADDR_CMD, 16'h0086);
        #1 chk(test_byte, ASCII_FIRST);
        chk(tx_mod, MOD_V29_9600);
        strobe(1'b0);
        #1 chk(test_byte, 8'h21);
        chk(test_active, 1'b1);
        strobe(1'b1);
        #1 chk(test_active, 1'b0);
        wr_reg(ADDR_CMD, 16'h1856);
        #1 chk(test_byte, SLIDE1_SEED);
        strobe(1'b0);
        #1 chk(test_byte, 8'h02);
        strobe(1'b1);
        wr_reg(ADDR_CMD, 16'h0307);
        rd_reg(ADDR_VALUE, v);
        chk(v[11:0], 12'h123);
        wr_reg(ADDR_CMD, 16'h0008);
        rd_reg(ADDR_RESULT, v);
        chk(v, RES_OK);
        wr_reg(ADDR_CMD, 16'h0009);
        wait_idle();
        wr_reg(ADDR_CMD, 16'h0307);
        rd_reg(ADDR_VALUE, v);
        chk(v[11:0], 12'h013);
        // Modem reset reloads the user values from the good store
        wr_reg(ADDR_CMD, 16'h000A);
        wait_idle();
        wr_reg(ADDR_CMD, 16'h0307);
        rd_reg(ADDR_VALUE, v);
        chk(v[11:0], 12'h123);
        // Second power-up with no store fitted falls back to the factory table
        @(posedge clk) {rst_n, nv_present} <= 2'b00;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        wait_idle();
        wr_reg(ADDR_CMD, 16'h0307);
        rd_reg(ADDR_VALUE, v);
        chk(v[11:0], 12'h013);
        complete_run();
    end
endmodule
`default_nettype wire

// file: verif/fci_nv_model.sv
// Purpose: Nonvolatile store model holding the user S-register values
// Assumes: Combinational read, data follows the address in the same cycle
// Notes:   S3 holds decimal 123 so a user load differs from the factory table
`default_nettype none
module fci_nv_model (
    input  wire logic [3:0] nv_addr,
    output logic      [7:0] nv_data
);
    timeunit 1ns;
    timeprecision 1ns;
    // User values: S3 marked, the rest echo their index
    assign nv_data = (nv_addr == 4'h3) ? 8'h7B : {4'h0, nv_addr};
endmodule
`default_nettype wire
